// ---- inc/uef_pkg.sv ----
// Constants shared by the endpoint register, sequencing and FIFO logic
package uef_pkg;
  // Register port geometry and byte offsets
  localparam int         ADDR_W   = 8;
  localparam int         DATA_W   = 32;
  localparam logic [7:0] OFS_CSR  = 8'h00;
  localparam logic [7:0] OFS_FIFO = 8'h04;
  localparam logic [7:0] OFS_TXVC = 8'h08;
  localparam logic [7:0] OFS_RST  = 8'h0C;

  // Control and status field positions
  localparam int CSR_TXDONE   = 0;
  localparam int CSR_SETUP    = 2;
  localparam int CSR_HALTACK  = 3;
  localparam int CSR_TXREADY  = 4;
  localparam int CSR_HALT     = 5;
  localparam int CSR_BANK1    = 6;
  localparam int CSR_DIR      = 7;
  localparam int CSR_TYPE_LO  = 8;
  localparam int CSR_TOGGLE   = 11;
  localparam int CSR_ENABLE   = 15;
  localparam int CSR_COUNT_LO = 16;
  localparam int TXVC_DIS     = 8;
  localparam int RST_EP       = 0;

  // Endpoint type encoding; top bit set means device to host
  localparam logic [2:0] TYPE_CONTROL = 3'h0;
  localparam int         TYPE_DIR_BIT = 2;

  // Handshake codes towards the serial engine
  localparam logic [1:0] HS_ACK   = 2'h0;
  localparam logic [1:0] HS_NAK   = 2'h1;
  localparam logic [1:0] HS_STALL = 2'h2;
  localparam logic [1:0] HS_DATA  = 2'h3;

  // Packet memory geometry
  localparam int                FIFO_DEPTH = 64;
  localparam int                FIFO_AW    = 6;
  localparam int                CNT_W      = 11;
  localparam logic [CNT_W-1:0]  FIFO_FULL  = 11'h040;

  // Reset values
  localparam logic [DATA_W-1:0] RESET_WORD = 32'h0000_0000;
endpackage

// ---- tb/uef_endpoint_tb.sv ----
// Self-checking bench for the endpoint registers and link answers
`timescale 1ns/1ps
module uef_endpoint_tb;
  import uef_pkg::*;
  logic              sys_clk = 1'b0;
  logic              sys_rst = 1'b1;
  logic              ce = 1'b1;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic              tok_in, tok_out, tok_setup, rx_valid, rx_end, rx_pid1;
  logic              host_ack, tx_pop, hs_valid, tx_pid1, tx_zlp;
  logic              ep_irq, txvr_off, rd_seen, pop_seen;
  logic [7:0]        rx_byte, tx_byte;
  logic [1:0]        hs_code;
  logic [3:0]        h;
  logic [DATA_W-1:0] exp_rd[$];
  logic [7:0]        exp_tx[$];
  logic [3:0]        exp_hs[$];
  logic [7:0]        pkt[$];
  int                n_fail = 0;
  int                samples_checked = 0;
  int                n;

  always #10 sys_clk = ~sys_clk;

  uef_endpoint u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .ce(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tok_in(tok_in),
    .tok_out(tok_out), .tok_setup(tok_setup), .rx_byte(rx_byte),
    .rx_valid(rx_valid), .rx_end(rx_end), .rx_pid1(rx_pid1),
    .host_ack(host_ack), .tx_pop(tx_pop), .hs_valid(hs_valid),
    .hs_code(hs_code), .tx_pid1(tx_pid1), .tx_zlp(tx_zlp),
    .tx_byte(tx_byte), .ep_irq(ep_irq), .txvr_off(txvr_off));
  uef_host_model u_host (.sys_clk(sys_clk), .tok_in(tok_in),
    .tok_out(tok_out), .tok_setup(tok_setup), .rx_byte(rx_byte),
    .rx_valid(rx_valid), .rx_end(rx_end), .rx_pid1(rx_pid1),
    .host_ack(host_ack), .tx_pop(tx_pop));

  task automatic chk(input string w, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", w, e, g);
    end
  endtask

  // Results that stand one cycle are taken off the queues here
  always @(posedge sys_clk)
  begin
    rd_seen  <= reg_rd;
    pop_seen <= tx_pop;
  end
  always @(negedge sys_clk)
  begin
    if (rd_seen === 1'b1)
      chk("reg_rdata", exp_rd.pop_front(), reg_rdata);
    if (pop_seen === 1'b1)
      chk("tx_byte", exp_tx.pop_front(), tx_byte);
    if (hs_valid === 1'b1 && exp_hs.size() == 0)
      chk("hs_valid", 0, 1);
    else if (hs_valid === 1'b1)
    begin
      h = exp_hs.pop_front();
      chk("hs_code", h[1:0], hs_code);
      if (h[1:0] == HS_DATA)
        chk("tx_pid1_zlp", h[3:2], {tx_pid1, tx_zlp});
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    exp_rd.push_back(e);
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic end_test(input string s);
    repeat (3) @(posedge sys_clk);
    chk("hs_pending", 0, exp_hs.size());
    $display("test %s done", s);
  endtask

  task automatic print_verdict;
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  function automatic logic [31:0] csr(input int c, input logic [15:0] lo);
    return {5'h00, 11'(c), lo};
  endfunction

  initial
  begin
    #400_000;
    n_fail++;
    print_verdict;
  end

  initial
  begin
    void'($urandom(32'h67c8f442));
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(OFS_CSR, 32'h0000_8000);
    wr(OFS_TXVC, 32'h0000_0100);
    chk("txvr_off", 1, txvr_off);
    rd(OFS_TXVC, 32'h0000_0100);
    wr(OFS_TXVC, 32'h0000_0000);
    chk("txvr_off", 0, txvr_off);
    // Clock held off: the write must not land
    ce <= 1'b0;
    wr(OFS_TXVC, 32'h0000_0100);
    ce <= 1'b1;
    chk("txvr_off", 0, txvr_off);
    wr(8'h10, 32'hffff_ffff);
    rd(8'h10, 32'h0000_0000);
    end_test("reset_txvc");
    // IN payload, then endpoint reset with a flag pending
    n = 1 + $urandom_range(14);
    wr(OFS_CSR, 32'h0000_00cd);
    for (int i = 0; i < n; i++)
    begin
      pkt.push_back(8'($urandom));
      wr(OFS_FIFO, {24'h00_0000, pkt[i]});
    end
    rd(OFS_CSR, csr(n, 16'h8080));
    wr(OFS_CSR, 32'h0000_00dd);
    rd(OFS_CSR, csr(n, 16'h8090));
    exp_hs.push_back({2'b00, HS_DATA});
    u_host.pulse(0);
    foreach (pkt[i])
    begin
      exp_tx.push_back(pkt[i]);
      u_host.pulse(5);
    end
    u_host.pulse(4);
    rd(OFS_CSR, 32'h0000_8881);
    chk("ep_irq", 1, ep_irq);
    for (int i = 0; i < 3; i++)
      wr(OFS_FIFO, 32'h0000_00a5);
    wr(OFS_RST, 32'h0000_0001);
    rd(OFS_CSR, 32'h0000_8081);
    wr(OFS_RST, 32'h0000_0000);
    wr(OFS_CSR, 32'h0000_00cc);
    rd(OFS_CSR, 32'h0000_8080);
    chk("ep_irq", 0, ep_irq);
    end_test("in_payload");
    // Forced halt answers with STALL and reports it
    wr(OFS_CSR, 32'h0000_00ed);
    exp_hs.push_back({2'b00, HS_STALL});
    u_host.pulse(0);
    rd(OFS_CSR, 32'h0000_80a8);
    chk("ep_irq", 1, ep_irq);
    wr(OFS_CSR, 32'h0000_00e5);
    rd(OFS_CSR, 32'h0000_80a0);
    // OUT data under halt is refused with STALL as well
    exp_hs.push_back({2'b00, HS_STALL});
    u_host.pulse(1);
    u_host.send(8'h99);
    u_host.pulse(3);
    rd(OFS_CSR, 32'h0000_80a8);
    wr(OFS_CSR, 32'h0000_00c5);
    rd(OFS_CSR, 32'h0000_8080);
    end_test("halt");
    // OUT into bank 1, refused while full, drained and released
    wr(OFS_CSR, 32'h0000_004d);
    pkt.delete();
    n = 1 + $urandom_range(14);
    u_host.pulse(1);
    for (int i = 0; i < n; i++)
    begin
      pkt.push_back(8'($urandom));
      u_host.send(pkt[i]);
    end
    exp_hs.push_back({2'b00, HS_ACK});
    u_host.pulse(3, 1'b1);
    rd(OFS_CSR, csr(n, 16'h8840));
    chk("ep_irq", 1, ep_irq);
    u_host.pulse(1);
    u_host.send(8'h3c);
    exp_hs.push_back({2'b00, HS_NAK});
    u_host.pulse(3, 1'b1);
    rd(OFS_CSR, csr(n, 16'h8840));
    foreach (pkt[i])
      rd(OFS_FIFO, {24'h00_0000, pkt[i]});
    wr(OFS_CSR, 32'h0000_004d);
    rd(OFS_CSR, 32'h0000_8840);
    chk("ep_irq", 1, ep_irq);
    wr(OFS_CSR, 32'h0000_000d);
    rd(OFS_CSR, 32'h0000_8800);
    exp_hs.push_back({2'b11, HS_DATA});
    u_host.pulse(0);
    end_test("out_bank1");
    // Every non-control endpoint type, enabled and disabled
    for (int t = 1; t < 8; t++)
    begin
      wr(OFS_CSR, {16'h0000, 5'h00, 3'(t), 8'h4d});
      rd(OFS_CSR, {16'h0000, 5'h01, 3'(t), 8'h00});
      wr(OFS_CSR, {16'h0000, 5'h10, 3'(t), 8'h4d});
      rd(OFS_CSR, {16'h0000, 5'h11, 3'(t), 8'h00});
    end
    wr(OFS_CSR, 32'h0000_024d);
    u_host.pulse(1);
    u_host.send(8'h77);
    u_host.pulse(3, 1'b1);
    wr(OFS_CSR, 32'h0000_004d);
    rd(OFS_CSR, 32'h0000_8800);
    end_test("types");
    // SETUP packet lands and resets the toggle
    u_host.pulse(2);
    for (int i = 0; i < 8; i++)
      u_host.send(8'(i));
    exp_hs.push_back({2'b00, HS_ACK});
    u_host.pulse(3, 1'b0);
    rd(OFS_CSR, csr(8, 16'h8004));
    rd(OFS_FIFO, 32'h0000_0000);
    end_test("setup");
    print_verdict;
  end
endmodule

// ---- tb/uef_host_model.sv ----
// Host and serial engine model driving the endpoint's link side
`timescale 1ns/1ps
module uef_host_model
(
  // Clock
  input  wire logic       sys_clk,
  // Link towards the endpoint
  output logic            tok_in,
  output logic            tok_out,
  output logic            tok_setup,
  output logic      [7:0] rx_byte,
  output logic            rx_valid,
  output logic            rx_end,
  output logic            rx_pid1,
  output logic            host_ack,
  output logic            tx_pop
);
  logic [5:0] strb;

  // Index: 0 IN, 1 OUT, 2 SETUP, 3 packet end, 4 host ack, 5 byte pop
  assign {tx_pop, host_ack, rx_end, tok_setup, tok_out, tok_in} =
    strb;

  initial
  begin
    strb     = '0;
    rx_byte  = 8'h5a;
    rx_valid = 1'b0;
    rx_pid1  = 1'b0;
  end

  task automatic pulse(input int k, input logic pid = 1'b0);
    @(posedge sys_clk);
    strb    <= 6'h01 << k;
    rx_pid1 <= pid;
    @(posedge sys_clk);
    strb    <= '0;
    rx_pid1 <= ~pid;
  endtask

  task automatic send(input logic [7:0] b);
    @(posedge sys_clk);
    rx_byte  <= b;
    rx_valid <= 1'b1;
    @(posedge sys_clk);
    // Idle data line must not keep showing the last byte
    rx_byte  <= ~b;
    rx_valid <= 1'b0;
  endtask
endmodule

// ---- verilog/uef_endpoint.sv ----
// Endpoint control, status and FIFO access for one USB device endpoint
//
// Chosen here: the address map and strobed register access.
`timescale 1ns/1ps
module uef_endpoint
(
  // Clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       sys_rst,
  input  wire logic                       ce,
  // Register port
  input  wire logic [uef_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [uef_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [uef_pkg::DATA_W-1:0] reg_rdata,
  // Serial engine events
  input  wire logic                       tok_in,
  input  wire logic                       tok_out,
  input  wire logic                       tok_setup,
  input  wire logic [7:0]                 rx_byte,
  input  wire logic                       rx_valid,
  input  wire logic                       rx_end,
  input  wire logic                       rx_pid1,
  input  wire logic                       host_ack,
  input  wire logic                       tx_pop,
  // Serial engine answers
  output logic                            hs_valid,
  output logic      [1:0]                 hs_code,
  output logic                            tx_pid1,
  output logic                            tx_zlp,
  output logic      [7:0]                 tx_byte,
  // Endpoint interrupt and transceiver
  output logic                            ep_irq,
  output logic                            txvr_off
);
  import uef_pkg::*;

  logic             tx_ready;
  logic             tx_done;
  logic             setup_rcvd;
  logic             halt_ack;
  logic             halt;
  logic             bank1_full;
  logic             dir;
  logic [2:0]       ep_type;
  logic             toggle;
  logic             ep_en;
  logic             ep_rst;
  logic             status_stage;
  logic             in_wait;
  logic             in_zlp;
  logic             rx_busy;
  logic             rx_setup;
  logic             rx_acc;
  logic             rx_stat;
  logic             wr_pend;
  logic [DATA_W-1:0] wr_q;
  logic [7:0]       fifo_q;
  logic [CNT_W-1:0] ep_count;

  // Address decode
  wire sel_csr  = (reg_addr == OFS_CSR);
  wire sel_fifo = (reg_addr == OFS_FIFO);
  wire sel_txvc = (reg_addr == OFS_TXVC);
  wire sel_rst  = (reg_addr == OFS_RST);

  // Endpoint state decode
  wire is_ctl   = (ep_type == TYPE_CONTROL);
  wire type_in  = ep_type[TYPE_DIR_BIT];
  wire ep_live  = is_ctl | ep_en;

  // Token decode; wrong-direction tokens on data endpoints are ignored
  wire in_go    = tok_in & ep_live & (is_ctl | type_in);
  wire in_stat  = is_ctl & ~dir;
  wire out_go   = tok_out & ep_live & (is_ctl | ~type_in);
  wire out_stat = is_ctl & dir;
  wire out_room = ~bank1_full & ~setup_rcvd;
  wire in_send  = ~halt & (in_stat | tx_ready);
  wire rx_fin   = rx_end & rx_busy;
  wire ack_in   = host_ack & in_wait;

  // FIFO steering
  wire fw_push   = reg_wr & sel_fifo;
  wire rx_push   = rx_valid & rx_busy & rx_acc & ~rx_stat;
  wire fifo_push = fw_push | rx_push;
  wire [7:0] fifo_wd = rx_push ? rx_byte : reg_wdata[7:0];
  wire fw_pop    = reg_rd & sel_fifo;
  wire fifo_pop  = fw_pop | tx_pop;
  wire fifo_clr  = ep_rst | tok_setup;

  // Control and status word as software sees it
  wire [DATA_W-1:0] csr_word = {5'h00, ep_count, ep_live, 3'h0, toggle,
                                ep_type, dir, bank1_full, halt, tx_ready,
                                halt_ack, setup_rcvd, 1'b0, tx_done};
  wire [DATA_W-1:0] rd_word =
    sel_csr  ? csr_word :
    sel_fifo ? {24'h00_0000, fifo_q} :
    sel_txvc ? (RESET_WORD | (DATA_W'(txvr_off) << TXVC_DIS)) :
    sel_rst  ? (RESET_WORD | DATA_W'(ep_rst)) :
    RESET_WORD;

  uef_fifo u_fifo
  (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .ce        (ce),
    .clear     (fifo_clr),
    .push      (fifo_push),
    .push_data (fifo_wd),
    .pop       (fifo_pop),
    .pop_data  (fifo_q),
    .count     (ep_count)
  );

  // Register read data and simple registers
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      reg_rdata <= RESET_WORD;
      txvr_off  <= 1'b0;
      ep_rst    <= 1'b0;
      wr_pend   <= 1'b0;
      wr_q      <= RESET_WORD;
      tx_byte   <= 8'h00;
      ep_irq    <= 1'b0;
    end
    else if (ce)
    begin
      reg_rdata <= reg_rd ? rd_word : RESET_WORD;
      if (reg_wr && sel_txvc)
        txvr_off <= reg_wdata[TXVC_DIS];
      if (reg_wr && sel_rst)
        ep_rst <= reg_wdata[RST_EP];
      wr_pend <= reg_wr & sel_csr;
      wr_q    <= reg_wdata;
      if (tx_pop)
        tx_byte <= fifo_q;
      ep_irq  <= tx_done | setup_rcvd | halt_ack | bank1_full;
    end
  end

  // Flags: firmware writes first so that hardware events win
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      tx_ready     <= 1'b0;
      tx_done      <= 1'b0;
      setup_rcvd   <= 1'b0;
      halt_ack     <= 1'b0;
      halt         <= 1'b0;
      bank1_full   <= 1'b0;
      dir          <= 1'b0;
      ep_type      <= TYPE_CONTROL;
      ep_en        <= 1'b0;
      toggle       <= 1'b0;
      status_stage <= 1'b0;
      in_wait      <= 1'b0;
      in_zlp       <= 1'b0;
    end
    else if (ce)
    begin
      if (wr_pend)
      begin
        if (wr_q[CSR_TXREADY])
          tx_ready <= 1'b1;
        if (!wr_q[CSR_TXDONE])
          tx_done <= 1'b0;
        if (!wr_q[CSR_SETUP])
          setup_rcvd <= 1'b0;
        if (!wr_q[CSR_HALTACK])
          halt_ack <= 1'b0;
        if (!wr_q[CSR_BANK1])
          bank1_full <= 1'b0;
        halt    <= wr_q[CSR_HALT];
        dir     <= wr_q[CSR_DIR];
        ep_type <= wr_q[CSR_TYPE_LO +: 3];
        if (!is_ctl)
          ep_en <= wr_q[CSR_ENABLE];
      end
      if (in_go)
      begin
        if (halt)
          halt_ack <= 1'b1;
        else if (in_send)
        begin
          in_wait <= 1'b1;
          in_zlp  <= in_stat;
          if (in_stat)
            status_stage <= 1'b1;
        end
      end
      if (ack_in)
      begin
        in_wait <= 1'b0;
        if (!in_zlp)
        begin
          tx_ready <= 1'b0;
          tx_done  <= 1'b1;
          toggle   <= ~toggle;
        end
      end
      if (tok_setup)
      begin
        status_stage <= 1'b0;
        in_wait      <= 1'b0;
      end
      if (rx_fin)
      begin
        if (rx_setup)
        begin
          setup_rcvd <= 1'b1;
          toggle     <= 1'b0;
        end
        else if (halt)
          halt_ack <= 1'b1;
        else if (rx_stat)
          status_stage <= 1'b1;
        else if (rx_acc)
        begin
          bank1_full <= 1'b1;
          toggle     <= rx_pid1;
        end
      end
      if (ep_rst)
        toggle <= 1'b0;
    end
  end

  // Receive sequencing and handshake answers
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      rx_busy  <= 1'b0;
      rx_setup <= 1'b0;
      rx_acc   <= 1'b0;
      rx_stat  <= 1'b0;
      hs_valid <= 1'b0;
      hs_code  <= HS_ACK;
      tx_pid1  <= 1'b0;
      tx_zlp   <= 1'b0;
    end
    else if (ce)
    begin
      hs_valid <= 1'b0;
      if (tok_setup)
      begin
        rx_busy  <= 1'b1;
        rx_setup <= 1'b1;
        rx_acc   <= 1'b1;
        rx_stat  <= 1'b0;
      end
      else if (out_go)
      begin
        rx_busy  <= 1'b1;
        rx_setup <= 1'b0;
        rx_acc   <= ~halt & (out_stat | out_room);
        rx_stat  <= out_stat;
      end
      else if (rx_fin)
        rx_busy <= 1'b0;
      if (rx_fin)
      begin
        hs_valid <= 1'b1;
        if (!rx_setup && halt)
          hs_code <= HS_STALL;
        else if (rx_acc)
          hs_code <= HS_ACK;
        else
          hs_code <= HS_NAK;
      end
      else if (in_go)
      begin
        hs_valid <= 1'b1;
        tx_pid1  <= in_stat | toggle;
        tx_zlp   <= in_stat;
        if (halt)
          hs_code <= HS_STALL;
        else if (in_send)
          hs_code <= HS_DATA;
        else
          hs_code <= HS_NAK;
      end
    end
  end

  halt_stall_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ce && in_go && !rx_fin && halt |=> hs_valid && hs_code == HS_STALL
    && halt_ack) else $error("forced halt not answered by STALL");
  halt_ack_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ce && rx_fin && !rx_setup && halt |=> halt_ack
    && hs_code == HS_STALL) else $error("STALL without ack flag");
  tx_done_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ce && ack_in && !in_zlp |=> tx_done && !tx_ready)
    else $error("ack did not complete transmit");
  bank1_irq_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ce && rx_fin && !rx_setup && !halt && rx_acc && !rx_stat
    |=> bank1_full ##1 (ep_irq || !$past(ce)))
    else $error("bank 1 packet not flagged");
  wr_sync_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ce && reg_wr && sel_csr ##1 ce |=> halt == $past(reg_wdata[CSR_HALT], 2)
    && dir == $past(reg_wdata[CSR_DIR], 2))
    else $error("flag write not applied after sync");
  status_zlp_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ce && in_go && !rx_fin && in_stat && !halt
    |=> hs_code == HS_DATA && tx_pid1 && tx_zlp)
    else $error("status stage not reversed");
  ep_reset_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ce && ep_rst |=> ep_count == '0 && !toggle)
    else $error("endpoint reset left data");
  fifo_read_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ce && reg_rd && sel_fifo |=> reg_rdata[DATA_W-1:8] == '0
    && reg_rdata[7:0] == $past(fifo_q))
    else $error("FIFO port read wrong");
  txvr_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ce && reg_wr && sel_txvc |=> txvr_off == $past(reg_wdata[TXVC_DIS]))
    else $error("transceiver disable not stored");
endmodule

// ---- verilog/uef_fifo.sv ----
// Byte FIFO holding one endpoint's packet memory
`timescale 1ns/1ps
module uef_fifo
(
  // Clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      sys_rst,
  input  wire logic                      ce,
  // Flush
  input  wire logic                      clear,
  // Push side
  input  wire logic                      push,
  input  wire logic [7:0]                push_data,
  // Pop side
  input  wire logic                      pop,
  output logic      [7:0]                pop_data,
  // Fill level
  output logic      [uef_pkg::CNT_W-1:0] count
);
  import uef_pkg::*;

  logic [7:0]         mem [FIFO_DEPTH];
  logic [FIFO_AW-1:0] wr_ptr;
  logic [FIFO_AW-1:0] rd_ptr;

  // Pushes beyond the memory are dropped
  wire do_push = push & (count != FIFO_FULL);
  wire do_pop  = pop & (count != '0);

  assign pop_data = mem[rd_ptr];

  always_ff @(posedge sys_clk)
  begin
    if (ce && do_push && !clear)
      mem[wr_ptr] <= push_data;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else if (ce)
    begin
      if (clear)
      begin
        wr_ptr <= '0;
        rd_ptr <= '0;
        count  <= '0;
      end
      else
      begin
        if (do_push)
          wr_ptr <= wr_ptr + 1'b1;
        if (do_pop)
          rd_ptr <= rd_ptr + 1'b1;
        if (do_push && !do_pop)
          count <= count + 1'b1;
        else if (do_pop && !do_push)
          count <= count - 1'b1;
      end
    end
  end

  fifo_bound_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    count <= FIFO_FULL) else $error("fifo count beyond depth");
endmodule
